//--- hw/xie_defs.svh
/*
  register map, field positions, reset values and line layout of the
  extended external interrupt enable/priority unit.
  assumes it is included by bare name from the unit's source files.
*/
`ifndef XIE_DEFS_SVH
`define XIE_DEFS_SVH

// special-function register addresses on the core's internal bus
`define XIE_ADDR_FLAGS     8'h91
`define XIE_ADDR_ENABLE    8'hE8
`define XIE_ADDR_PRIORITY  8'hF8

// reset values as seen on reads
`define XIE_ENABLE_RST     8'hE0
`define XIE_PRIORITY_RST   8'hE0
`define XIE_FLAGS_RST      8'h08

// reserved bits: 7..5 of enable/priority read one, bit 4 reads zero
`define XIE_CTRL_RSVD_HI   3'h7
`define XIE_CTRL_RSVD_B4   1'h0
// reserved bits of the flag register: bit 3 reads one, 2..0 read zero
`define XIE_FLAGS_RSVD_LO  4'h8

// field positions
`define XIE_CTRL_LSB       0
`define XIE_FLAGS_LSB      4
`define XIE_NUM_LINES      4

// lines 3 (five) and 1 (three) are falling-edge, 2 (four) and 0 (two) rising
`define XIE_FALL_MASK      4'hA
`define XIE_RD_UNMAPPED    8'h00

`endif

//--- hw/xie_pkg.sv
/*
  state types of the extended external interrupt enable/priority unit.
  assumes xie_defs.svh supplies the field widths.
*/
`include "xie_defs.svh"

package xie_pkg;

    typedef struct packed {
        logic pin_prev;
        logic event_r;
    } xie_edge_state_t;

    typedef struct packed {
        logic [`XIE_NUM_LINES-1:0] enable;
        logic [`XIE_NUM_LINES-1:0] level;
        logic [`XIE_NUM_LINES-1:0] pending;
        logic [`XIE_NUM_LINES-1:0] req;
        logic [`XIE_NUM_LINES-1:0] high;
        logic [7:0]                rdata;
    } xie_state_t;

endpackage

//--- hw/xie_edge_det.sv
/*
  single-line edge detector: a one-cycle pulse for each active edge.
  assumes the pin is synchronous to CLK; FALLING selects the active edge.
*/
`timescale 1ns/100ps
`default_nettype none

module xie_edge_det #(
    parameter bit FALLING = 1'b0
) (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic pin,
    output logic      event_pulse
);

    xie_pkg::xie_edge_state_t state_r;
    xie_pkg::xie_edge_state_t state_nxt;

    always_comb begin
        state_nxt          = state_r;
        state_nxt.pin_prev = pin;
        state_nxt.event_r  = FALLING ? (state_r.pin_prev & ~pin)
                                     : (~state_r.pin_prev & pin);
    end

    // idle level preloaded so a pin resting at idle gives no false edge
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r.pin_prev <= FALLING;
            state_r.event_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign event_pulse = state_r.event_r;

endmodule // xie_edge_det

`default_nettype wire

//--- hw/xie_top.sv
/*
  extended external interrupt lines five..two: enable, priority and pending
  flags on the core's special-function register port, one request and one
  level bit per line toward the core's vectoring logic.
  assumes pins and register strobes are synchronous to CLK and that the
  core samples SFR_RDATA one cycle after SFR_RD.
*/
//
// Overview of operation
// RQ1: enable and priority bits 7..5 read one, ignore writes; reset 0xE0.
// RQ2: bit 4 of enable and priority reads zero; firmware writes zero.
// RQ3: enable bit 3 gates line five requests.
// RQ4: enable bit 2 gates line four requests.
// RQ5: enable bit 1 gates line three requests.
// RQ6: enable bit 0 gates line two requests.
// RQ7: priority bit 3 sets line five high (1) or low (0).
// RQ8: priority bit 2 sets line four high (1) or low (0).
// RQ9: priority bit 1 sets line three high (1) or low (0).
// RQ10: priority bit 0 sets line two high (1) or low (0).
// RQ11: falling edge on line five or three pin sets its pending flag.
// RQ12: rising edge on line four or two pin sets its pending flag.
// RQ13: flags hold until firmware clears; firmware setting one requests if enabled.
// RQ14: request per line when pending and enabled, tagged with its priority level.
`timescale 1ns/100ps
`default_nettype none
`include "xie_defs.svh"

module xie_top (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       LINE_FIVE_FALL_PIN,
    input  wire logic       LINE_FOUR_RISE_PIN,
    input  wire logic       LINE_THREE_FALL_PIN,
    input  wire logic       LINE_TWO_RISE_PIN,
    output logic      [3:0] IRQ_REQ,
    output logic      [3:0] IRQ_HIGH
);

    xie_pkg::xie_state_t state_r;
    xie_pkg::xie_state_t state_nxt;

    logic [`XIE_NUM_LINES-1:0] line_pins;
    logic [`XIE_NUM_LINES-1:0] line_event;
    logic                      wr_enable;
    logic                      wr_priority;
    logic                      wr_flags;

    // bit gi of the mask picks the detector direction for line gi
    localparam logic [`XIE_NUM_LINES-1:0] FALL_MASK = `XIE_FALL_MASK;

    assign line_pins = {LINE_FIVE_FALL_PIN, LINE_FOUR_RISE_PIN,
                        LINE_THREE_FALL_PIN, LINE_TWO_RISE_PIN};

    // one detector per line; direction fixed by the line's position
    genvar gi;
    generate
        for (gi = 0; gi < `XIE_NUM_LINES; gi = gi + 1) begin : g_line
            xie_edge_det #(
                .FALLING (FALL_MASK[gi])  // [RQ11] [RQ12]
            ) u_edge (
                .CLK         (CLK),
                .RST         (RST),
                .pin         (line_pins[gi]),
                .event_pulse (line_event[gi])
            );
        end
    endgenerate

    assign wr_enable   = SFR_WR && (SFR_ADDR == `XIE_ADDR_ENABLE);
    assign wr_priority = SFR_WR && (SFR_ADDR == `XIE_ADDR_PRIORITY);
    assign wr_flags    = SFR_WR && (SFR_ADDR == `XIE_ADDR_FLAGS);

    always_comb begin
        state_nxt = state_r;

        // only the low nibble is stored; upper bits are constants on read
        if (wr_enable) begin
            state_nxt.enable = SFR_WDATA[`XIE_CTRL_LSB +: 4];  // [RQ1] [RQ2]
        end
        if (wr_priority) begin
            state_nxt.level = SFR_WDATA[`XIE_CTRL_LSB +: 4];  // [RQ7] [RQ8] [RQ9] [RQ10]
        end

        // an edge in the same cycle as a clearing write still sets the flag
        if (wr_flags) begin
            state_nxt.pending = SFR_WDATA[`XIE_FLAGS_LSB +: 4] | line_event;  // [RQ13]
        end else begin
            state_nxt.pending = state_r.pending | line_event;  // [RQ11] [RQ12] [RQ13]
        end

        // gating from the stored state keeps the request one cycle behind the flag
        state_nxt.req  = state_r.pending & state_r.enable;  // [RQ3] [RQ4] [RQ5] [RQ6] [RQ14]
        state_nxt.high = state_r.level;  // [RQ14]

        if (SFR_RD) begin
            case (SFR_ADDR)
                `XIE_ADDR_ENABLE: begin
                    state_nxt.rdata = {`XIE_CTRL_RSVD_HI, `XIE_CTRL_RSVD_B4,
                                       state_r.enable};  // [RQ1] [RQ2]
                end
                `XIE_ADDR_PRIORITY: begin
                    state_nxt.rdata = {`XIE_CTRL_RSVD_HI, `XIE_CTRL_RSVD_B4,
                                       state_r.level};  // [RQ1] [RQ2]
                end
                `XIE_ADDR_FLAGS: begin
                    state_nxt.rdata = {state_r.pending, `XIE_FLAGS_RSVD_LO};
                end
                default: begin
                    state_nxt.rdata = `XIE_RD_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r.enable  <= 4'h0;
            state_r.level   <= 4'h0;
            state_r.pending <= 4'h0;
            state_r.req     <= 4'h0;
            state_r.high    <= 4'h0;
            state_r.rdata   <= 8'h00;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign SFR_RDATA = state_r.rdata;
    assign IRQ_REQ   = state_r.req;
    assign IRQ_HIGH  = state_r.high;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    property p_enable_rsvd_read;
        SFR_RD && (SFR_ADDR == `XIE_ADDR_ENABLE) |=> SFR_RDATA[7:5] == 3'h7;
    endproperty
    a_enable_rsvd_read: assert property (p_enable_rsvd_read)  // [RQ1]
        else $error("enable register reserved high bits not read as one");

    property p_ctrl_bit4_zero;
        SFR_RD && ((SFR_ADDR == `XIE_ADDR_ENABLE) || (SFR_ADDR == `XIE_ADDR_PRIORITY))
            |=> SFR_RDATA[4] == 1'b0 && SFR_RDATA[7:5] == 3'h7;
    endproperty
    a_ctrl_bit4_zero: assert property (p_ctrl_bit4_zero)  // [RQ2]
        else $error("control register bit 4 not read as zero");

    // edge -> detector -> flag -> request: three registers between pin and output
    property p_five_fall_requests;
        $fell(LINE_FIVE_FALL_PIN) && state_r.enable[3] && !SFR_WR ##1 !SFR_WR
            |-> ##2 IRQ_REQ[3];
    endproperty
    a_five_fall_requests: assert property (p_five_fall_requests)  // [RQ3]
        else $error("line five edge with enable set gave no request");

    property p_four_rise_requests;
        $rose(LINE_FOUR_RISE_PIN) && state_r.enable[2] && !SFR_WR ##1 !SFR_WR
            |-> ##2 IRQ_REQ[2];
    endproperty
    a_four_rise_requests: assert property (p_four_rise_requests)  // [RQ4] [RQ12]
        else $error("line four edge with enable set gave no request");

    property p_three_disabled_quiet;
        !state_r.enable[1] && !wr_enable |=> !IRQ_REQ[1] [*2];
    endproperty
    a_three_disabled_quiet: assert property (p_three_disabled_quiet)  // [RQ5]
        else $error("line three requested while disabled");

    property p_two_disabled_quiet;
        !state_r.enable[0] && !wr_enable |=> !IRQ_REQ[0] [*2];
    endproperty
    a_two_disabled_quiet: assert property (p_two_disabled_quiet)  // [RQ6]
        else $error("line two requested while disabled");

    property p_priority_follows_write;
        wr_priority ##1 !wr_priority |=> IRQ_HIGH == $past(SFR_WDATA[3:0], 2);
    endproperty
    a_priority_follows_write: assert property (p_priority_follows_write)  // [RQ7] [RQ8] [RQ9] [RQ10]
        else $error("priority level output does not follow the written value");

    property p_three_fall_sets_flag;
        $fell(LINE_THREE_FALL_PIN) |-> ##2 state_r.pending[1];
    endproperty
    a_three_fall_sets_flag: assert property (p_three_fall_sets_flag)  // [RQ11]
        else $error("line three falling edge did not set its flag");

    property p_two_rise_sets_flag;
        $rose(LINE_TWO_RISE_PIN) |-> ##2 state_r.pending[0];
    endproperty
    a_two_rise_sets_flag: assert property (p_two_rise_sets_flag)  // [RQ12]
        else $error("line two rising edge did not set its flag");

    property p_flag_holds;
        state_r.pending[2] && !wr_flags |=> state_r.pending[2];
    endproperty
    a_flag_holds: assert property (p_flag_holds)  // [RQ13]
        else $error("line four flag cleared without a write");

    property p_soft_set_requests;
        wr_flags && SFR_WDATA[4] && state_r.enable[0] && !wr_enable ##1 !wr_enable
            |-> ##1 IRQ_REQ[0];
    endproperty
    a_soft_set_requests: assert property (p_soft_set_requests)  // [RQ13] [RQ14]
        else $error("firmware-set line two flag gave no request");

    property p_req_needs_cause;
        IRQ_REQ[3] |-> $past(state_r.pending[3]) && $past(state_r.enable[3]);
    endproperty
    a_req_needs_cause: assert property (p_req_needs_cause)  // [RQ14]
        else $error("line five request without pending flag and enable");

    c_five_request:  cover property ($fell(LINE_FIVE_FALL_PIN) ##3 IRQ_REQ[3]);
    c_soft_request:  cover property (wr_flags && SFR_WDATA[6] ##2 IRQ_REQ[2]);
    c_high_request:  cover property (IRQ_REQ[1] && IRQ_HIGH[1]);
    c_clear_race:    cover property (wr_flags && !SFR_WDATA[4] && line_event[0]);

endmodule // xie_top

`default_nettype wire

//--- test/xie_core_model.sv
/*
  core-side model: firmware reads and writes on the special-function port.
  assumes CLK from the bench; strobes are one-cycle pulses set 1 ns after an edge.
*/
`timescale 1ns/100ps
`default_nettype none
`include "xie_defs.svh"

module xie_core_model (
    input  wire logic       CLK,
    input  wire logic [7:0] SFR_RDATA,
    output var  logic [7:0] SFR_ADDR,
    output var  logic       SFR_WR,
    output var  logic       SFR_RD,
    output var  logic [7:0] SFR_WDATA
);
    initial begin
        SFR_ADDR = 8'h00;
        SFR_WR = 1'b0;
        SFR_RD = 1'b0;
        SFR_WDATA = 8'h00;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge CLK) #1;
        SFR_ADDR = a;
        // firmware never sets bit 4 of enable or priority
        SFR_WDATA = (a == `XIE_ADDR_FLAGS) ? v : (v & 8'hEF);
        SFR_WR = 1'b1;
        @(posedge CLK) #1;
        SFR_WR = 1'b0;
        // stale data would hide a late sample
        SFR_WDATA = ~SFR_WDATA;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge CLK) #1;
        SFR_ADDR = a;
        SFR_RD = 1'b1;
        @(posedge CLK) #1;
        SFR_RD = 1'b0;
        v = SFR_RDATA;
    endtask
endmodule // xie_core_model

`default_nettype wire

//--- test/xie_top_tb.sv
/*
  self-checking bench of the extended external interrupt unit.
  assumes xie_core_model owns the register port; pins move 1 ns after an edge.
*/
`timescale 1ns/100ps
`default_nettype none
`include "xie_defs.svh"

module xie_top_tb;
    logic       clk;
    logic       rst;
    logic [3:0] pins;
    logic [7:0] addr, wdata, rdata, d;
    logic       wr, rd;
    logic [3:0] req, high;
    int         error_cnt = 0;
    int         checked = 0;

    xie_top dut (.CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd),
        .SFR_WDATA(wdata), .SFR_RDATA(rdata), .LINE_FIVE_FALL_PIN(pins[3]),
        .LINE_FOUR_RISE_PIN(pins[2]), .LINE_THREE_FALL_PIN(pins[1]),
        .LINE_TWO_RISE_PIN(pins[0]), .IRQ_REQ(req), .IRQ_HIGH(high));
    xie_core_model core (.CLK(clk), .SFR_RDATA(rdata), .SFR_ADDR(addr), .SFR_WR(wr),
        .SFR_RD(rd), .SFR_WDATA(wdata));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // active edge on the masked lines, held two cycles, then back to idle
    task automatic pulse(input logic [3:0] m);
        pins = pins ^ m;
        settle(2);
        pins = pins ^ m;
        settle(2);
    endtask

    task automatic t_reset_values();
        chk({req, high}, 8'h00);
        core.rd_reg(`XIE_ADDR_ENABLE, d);
        chk(d, 8'hE0);
        core.rd_reg(`XIE_ADDR_PRIORITY, d);
        chk(d, 8'hE0);
        core.rd_reg(`XIE_ADDR_FLAGS, d);
        chk(d, 8'h08);
        core.rd_reg(8'h55, d);
        chk(d, 8'h00);
    endtask

    task automatic t_ctrl_regs();
        core.wr_reg(`XIE_ADDR_ENABLE, 8'hFA);
        core.rd_reg(`XIE_ADDR_ENABLE, d);
        chk(d, 8'hEA);
        core.wr_reg(`XIE_ADDR_PRIORITY, 8'h05);
        settle(1);
        chk({4'h0, high}, 8'h05);
        core.rd_reg(`XIE_ADDR_PRIORITY, d);
        chk(d, 8'hE5);
        core.wr_reg(`XIE_ADDR_PRIORITY, 8'h0A);
        settle(1);
        chk({4'h0, high}, 8'h0A);
    endtask

    task automatic t_lines();
        for (int i = 0; i < 4; i++) begin
            core.wr_reg(`XIE_ADDR_ENABLE, 8'h01 << i);
            pulse(4'h1 << i);
            chk({4'h0, req}, 8'h01 << i);
            settle(10);
            core.rd_reg(`XIE_ADDR_FLAGS, d);
            chk(d, (8'h10 << i) | 8'h08);
            core.wr_reg(`XIE_ADDR_FLAGS, 8'h00);
            settle(1);
            chk({4'h0, req}, 8'h00);
        end
        core.wr_reg(`XIE_ADDR_ENABLE, 8'h00);
        pulse(4'hF);
        chk({4'h0, req}, 8'h00);
        core.rd_reg(`XIE_ADDR_FLAGS, d);
        chk(d, 8'hF8);
        core.wr_reg(`XIE_ADDR_ENABLE, 8'h0F);
        settle(1);
        chk({4'h0, req}, 8'h0F);
        core.wr_reg(`XIE_ADDR_FLAGS, 8'h00);
    endtask

    task automatic t_soft_set();
        core.wr_reg(`XIE_ADDR_ENABLE, 8'h05);
        core.wr_reg(`XIE_ADDR_FLAGS, 8'hF0);
        settle(1);
        chk({4'h0, req}, 8'h05);
        core.rd_reg(`XIE_ADDR_FLAGS, d);
        chk(d, 8'hF8);
        core.wr_reg(`XIE_ADDR_FLAGS, 8'h00);
        settle(1);
        chk({4'h0, req}, 8'h00);
    endtask

    initial begin
        rst = 1'b1;
        pins = `XIE_FALL_MASK;
        settle(6);
        rst = 1'b0;
        t_reset_values();
        t_ctrl_regs();
        t_lines();
        t_soft_set();
        report_and_stop();
    end

    // the whole run needs about 135 cycles
    initial begin
        settle(3000);
        error_cnt++;
        report_and_stop();
    end
endmodule // xie_top_tb

`default_nettype wire
